/* File: pkg/dac_event_defs.svh */
// Purpose: Register offsets, field positions and reset values of the event/status block.
// Assumes: 13-bit register address space reached over the serial configuration port.
// Notes:   Definitions only.
`ifndef DAC_EVENT_DEFS_SVH
`define DAC_EVENT_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_CLIP_SAMPLE_COUNT 13'h0001
`define OFS_PARITY_FAULT_COUNT 13'h0002
`define OFS_EVENT_ENABLE_MASK 13'h0003
`define OFS_EVENT_STATUS_CLEAR 13'h0004
`define OFS_CHANNEL_ON_MASK 13'h0005
`define OFS_SUMMING_GAIN 13'h0008

// ----------------------------------------------------------------
// Status and enable bit positions
// ----------------------------------------------------------------
`define BIT_PARITY_FAULT 7
`define BIT_SELF_TEST_DONE 6
`define BIT_PARAM_SET 5
`define BIT_PARAM_CLEARED 4
`define BIT_HANDOFF_ALIGNED 3
`define BIT_HANDOFF_LOST 2
`define BIT_OVERFLOW 1

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define MASK_EVENT_BITS 8'hFE
`define MASK_STATUS_W1C 8'hF6
`define MASK_CHANNEL_ON 8'h0F
`define RST_EVENT_ENABLE_MASK 8'h00
`define RST_EVENT_STATUS 8'h00
`define RST_CHANNEL_ON_MASK 8'h00
`define RST_SUMMING_GAIN 8'h0D
`define GAIN_FRAC_BITS 6

// ----------------------------------------------------------------
// Serial port framing
// ----------------------------------------------------------------
`define SPI_INSTR_LAST 4'hF
`define SPI_DATA_LAST 4'h7
`define SPI_RW_BIT 14

`endif

/* File: pkg/dac_event_pkg.sv */
// Purpose: Types shared by the event/status block.
// Assumes: Constants live in dac_event_defs.svh.
// Notes:   Types only.
package dac_event_pkg;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_INSTR = 2'b01,
        SPI_DATA = 2'b10
    } spi_state_t;

    typedef logic [7:0] reg_byte_t;
    typedef logic [12:0] reg_addr_t;

endpackage

/* File: pkg/count_if.sv */
// Purpose: Carries increment, clear and count between the block and one event counter.
// Assumes: Single clock domain.
// Notes:   Owner drives the strobes, the counter returns its value.
`timescale 1ns/1ps
interface count_if #(parameter int W = 8);
    logic inc;
    logic clr;
    logic [W-1:0] count;

    modport owner (output inc, output clr, input count);
    modport counter (input inc, input clr, output count);
endinterface

/* File: hdl/event_counter.sv */
// Purpose: Saturating event counter with synchronous clear.
// Assumes: inc and clr are one-cycle strobes in the clk domain.
// Notes:   An increment in the clear cycle is kept, so the count restarts at one.
`timescale 1ns/1ps
module event_counter #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    count_if.counter cnt
);
    logic [W-1:0] count_r;
    logic at_max;

    assign at_max = &count_r;
    assign cnt.count = count_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
        end else if (ce) begin
            if (cnt.clr) begin
                count_r <= cnt.inc ? W'(1) : '0;
            end else if (cnt.inc && !at_max) begin
                count_r <= count_r + W'(1);
            end
        end
    end
endmodule

/* File: hdl/dac_event_status.sv */
// Purpose: Event counters, interrupt enable/status, channel enables and summing gain stage
//          behind the serial configuration port.
// Assumes: All pins except arst_n, including the serial clock, are synchronous to clk and far slower.
// Notes:   Serial port is 4-wire, MSB first, 16-bit instruction, streaming with address
//          increment until chip select rises.
//          Byte-count bits of the instruction are ignored; LSB-first is not supported.
`include "dac_event_defs.svh"
`timescale 1ns/1ps
module dac_event_status
    import dac_event_pkg::*;
#(
    parameter int DW = 16,
    parameter int CW = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    input wire logic [DW-1:0] sum_sample,
    input wire logic sum_valid,
    output logic [DW-1:0] scaled_sample,
    output logic scaled_valid,
    input wire logic parity_fault_event,
    input wire logic self_test_finished_event,
    input wire logic param_update_set_event,
    input wire logic param_update_cleared_event,
    input wire logic handoff_aligned_event,
    input wire logic handoff_lost_event,
    input wire logic overflow_event,
    output logic [3:0] channel_on,
    output logic irq_n
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    spi_state_t spi_st_r;
    logic [3:0] bit_cnt_r;
    logic [15:0] shin_r;
    reg_addr_t addr_r;
    logic rd_r;
    logic sclk_d_r;
    reg_byte_t rd_sh_r;
    logic sdo_r;
    logic sdo_oe_r;

    logic sclk_rise;
    logic sclk_fall;
    logic instr_done;
    logic byte_done;
    reg_addr_t rd_addr;
    reg_byte_t rd_val;
    logic wr_go;
    reg_byte_t wr_data;

    reg_byte_t enable_r;
    reg_byte_t status_r;
    reg_byte_t status_nxt;
    reg_byte_t set_vec;
    reg_byte_t clr_vec;
    reg_byte_t chan_r;
    reg_byte_t gain_r;
    logic irq_n_r;

    logic [DW-1:0] scaled_r;
    logic scaled_valid_r;
    logic clip_r;
    logic [DW+8:0] product;
    logic [DW+2:0] shifted;
    logic over_hi;
    logic over_lo;

    // One interface per counter keeps strobe, clear and value together
    count_if #(.W(CW)) clip_cnt_if ();
    count_if #(.W(CW)) par_cnt_if ();

    // ----------------------------------------------------------------
    // Serial port framing
    // ----------------------------------------------------------------
    // Serial clock edges are found against last cycle's sample, so the host must
    // hold each clock phase for at least one cycle or an edge is lost.
    assign sclk_rise = spi_sclk & ~sclk_d_r;
    assign sclk_fall = ~spi_sclk & sclk_d_r;
    assign instr_done = !spi_cs_n && sclk_rise && (spi_st_r != SPI_DATA) && (bit_cnt_r == `SPI_INSTR_LAST);
    assign byte_done = !spi_cs_n && sclk_rise && (spi_st_r == SPI_DATA) && (bit_cnt_r == `SPI_DATA_LAST);
    assign wr_go = byte_done && !rd_r;
    assign wr_data = {shin_r[6:0], spi_sdi};

    // Address of the byte to preload for a read: the one just named, or the next one
    always_comb begin
        if (spi_st_r == SPI_DATA) begin
            rd_addr = addr_r + 13'h0001;
        end else begin
            rd_addr = {shin_r[11:0], spi_sdi};
        end
    end

    // Chip select low in mode 0 means the clock idles low, so the first rising edge
    // may come in the very cycle after the select falls; idle and instruction share a path.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            spi_st_r <= SPI_IDLE;
            bit_cnt_r <= 4'h0;
            shin_r <= 16'h0000;
            addr_r <= 13'h0000;
            rd_r <= 1'b0;
            sclk_d_r <= 1'b0;
        end else if (ce) begin
            sclk_d_r <= spi_sclk;
            // A rising chip select drops any partial byte and rearms for a new instruction
            if (spi_cs_n) begin
                spi_st_r <= SPI_IDLE;
                bit_cnt_r <= 4'h0;
            end else begin
                case (spi_st_r)
                    SPI_IDLE, SPI_INSTR: begin
                        spi_st_r <= SPI_INSTR;
                        if (sclk_rise) begin
                            shin_r <= {shin_r[14:0], spi_sdi};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (instr_done) begin
                                rd_r <= shin_r[`SPI_RW_BIT];
                                addr_r <= {shin_r[11:0], spi_sdi};
                                bit_cnt_r <= 4'h0;
                                spi_st_r <= SPI_DATA;
                            end
                        end
                    end
                    SPI_DATA: begin
                        if (sclk_rise) begin
                            shin_r <= {shin_r[14:0], spi_sdi};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                            if (byte_done) begin
                                bit_cnt_r <= 4'h0;
                                addr_r <= addr_r + 13'h0001;
                            end
                        end
                    end
                    default: begin
                        spi_st_r <= SPI_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Reads have no side effects; pulse status bits clear only by an explicit write of ones, the aligned bit follows its level.
    // Unmapped addresses read as zero, so software may probe the map safely.
    always_comb begin
        if (rd_addr == `OFS_CLIP_SAMPLE_COUNT) begin
            rd_val = clip_cnt_if.count;
        end else if (rd_addr == `OFS_PARITY_FAULT_COUNT) begin
            rd_val = par_cnt_if.count;
        end else if (rd_addr == `OFS_EVENT_ENABLE_MASK) begin
            rd_val = enable_r;
        end else if (rd_addr == `OFS_EVENT_STATUS_CLEAR) begin
            rd_val = status_r;
        end else if (rd_addr == `OFS_CHANNEL_ON_MASK) begin
            rd_val = chan_r;
        end else if (rd_addr == `OFS_SUMMING_GAIN) begin
            rd_val = gain_r;
        end else begin
            rd_val = 8'h00;
        end
    end

    // Data leaves on falling edges so the host can sample on rising ones
    // Output enable drops in the cycle after chip select rises, never mid-frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_sh_r <= 8'h00;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (ce) begin
            if (instr_done || byte_done) begin
                rd_sh_r <= rd_val;
            end else if (sclk_fall && spi_st_r == SPI_DATA && rd_r && !spi_cs_n) begin
                sdo_r <= rd_sh_r[7];
                rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
            sdo_oe_r <= !spi_cs_n && spi_st_r == SPI_DATA && rd_r;
        end
    end

    assign spi_sdo = sdo_r;
    assign spi_sdo_oe = sdo_oe_r;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Reserved bits are masked on write, so they always read back zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_r <= `RST_EVENT_ENABLE_MASK;
        end else if (ce && wr_go && addr_r == `OFS_EVENT_ENABLE_MASK) begin
            enable_r <= wr_data & `MASK_EVENT_BITS;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            chan_r <= `RST_CHANNEL_ON_MASK;
        end else if (ce && wr_go && addr_r == `OFS_CHANNEL_ON_MASK) begin
            chan_r <= wr_data & `MASK_CHANNEL_ON;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_r <= `RST_SUMMING_GAIN;
        end else if (ce && wr_go && addr_r == `OFS_SUMMING_GAIN) begin
            gain_r <= wr_data;
        end
    end

    // ----------------------------------------------------------------
    // Event status
    // ----------------------------------------------------------------
    // Pulse events latch here; the aligned bit is copied as a level instead
    always_comb begin
        set_vec = 8'h00;
        set_vec[`BIT_PARITY_FAULT] = parity_fault_event;
        set_vec[`BIT_SELF_TEST_DONE] = self_test_finished_event;
        set_vec[`BIT_PARAM_SET] = param_update_set_event;
        set_vec[`BIT_PARAM_CLEARED] = param_update_cleared_event;
        set_vec[`BIT_HANDOFF_LOST] = handoff_lost_event;
        set_vec[`BIT_OVERFLOW] = overflow_event;
        set_vec = set_vec & enable_r;
        clr_vec = 8'h00;
        if (wr_go && addr_r == `OFS_EVENT_STATUS_CLEAR) begin
            clr_vec = wr_data & `MASK_STATUS_W1C;
        end
        // A new event in the clearing cycle survives the clear
        status_nxt = (status_r & ~clr_vec) | set_vec;
        status_nxt[`BIT_HANDOFF_ALIGNED] = handoff_aligned_event;
        status_nxt[0] = 1'b0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_r <= `RST_EVENT_STATUS;
        end else if (ce) begin
            status_r <= status_nxt;
        end
    end

    // Aligned bit is a live level, so it keeps the pin low while enabled and aligned
    // Taken from registered status, so the pin lags an event by two cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_n_r <= 1'b1;
        end else if (ce) begin
            irq_n_r <= ~|(status_r & enable_r);
        end
    end

    assign irq_n = irq_n_r;
    assign channel_on = chan_r[3:0];

    // ----------------------------------------------------------------
    // Summing gain stage with clip detection
    // ----------------------------------------------------------------
    // Gain reaches almost 4, so three guard bits above the sample width catch every overrange
    // Clipping instead of wrapping keeps an overdriven carrier from flipping sign
    assign product = $signed(sum_sample) * $signed({1'b0, gain_r});
    assign shifted = product[DW+8:`GAIN_FRAC_BITS];
    assign over_hi = !shifted[DW+2] && (shifted[DW+1:DW-1] != 3'h0);
    assign over_lo = shifted[DW+2] && (shifted[DW+1:DW-1] != 3'h7);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scaled_r <= '0;
            scaled_valid_r <= 1'b0;
            clip_r <= 1'b0;
        end else if (ce) begin
            scaled_valid_r <= sum_valid;
            clip_r <= sum_valid && (over_hi || over_lo);
            if (sum_valid) begin
                if (over_hi) begin
                    scaled_r <= {1'b0, {(DW-1){1'b1}}};
                end else if (over_lo) begin
                    scaled_r <= {1'b1, {(DW-1){1'b0}}};
                end else begin
                    scaled_r <= shifted[DW-1:0];
                end
            end
        end
    end

    assign scaled_sample = scaled_r;
    assign scaled_valid = scaled_valid_r;

    // ----------------------------------------------------------------
    // Event counters
    // ----------------------------------------------------------------
    // Counts and clears ignore the enable mask, so they work with interrupts off
    assign clip_cnt_if.inc = clip_r;
    assign clip_cnt_if.clr = wr_go && addr_r == `OFS_EVENT_STATUS_CLEAR && wr_data[`BIT_OVERFLOW];
    assign par_cnt_if.inc = parity_fault_event;
    assign par_cnt_if.clr = wr_go && addr_r == `OFS_EVENT_STATUS_CLEAR && wr_data[`BIT_PARITY_FAULT];

    event_counter #(.W(CW)) clip_counter (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .cnt(clip_cnt_if)
    );

    event_counter #(.W(CW)) parity_counter (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .cnt(par_cnt_if)
    );

endmodule

/* File: testbench/dac_event_status_sva.sv */
// Purpose: Port-level assertions for the event/status block.
// Assumes: Single clock domain, arst_n asynchronous active low.
// Notes:   Enable and status registers are not visible here, so irq checks tie pin moves to causes.
`timescale 1ns/1ps
module dac_event_status_sva #(
    parameter int DW = 16,
    parameter int CW = 8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic spi_cs_n,
    input wire logic [DW-1:0] sum_sample,
    input wire logic sum_valid,
    input wire logic [DW-1:0] scaled_sample,
    input wire logic scaled_valid,
    input wire logic parity_fault_event,
    input wire logic self_test_finished_event,
    input wire logic param_update_set_event,
    input wire logic param_update_cleared_event,
    input wire logic handoff_aligned_event,
    input wire logic handoff_lost_event,
    input wire logic overflow_event,
    input wire logic [3:0] channel_on,
    input wire logic irq_n
);
    logic any_ev;
    assign any_ev = parity_fault_event | self_test_finished_event | param_update_set_event |
        param_update_cleared_event | handoff_aligned_event | handoff_lost_event | overflow_event;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Gain stage
    // ------------------------------------------------------------
    sequence sample_s;
        sum_valid ##1 scaled_valid;
    endsequence
    a_scaled_follows_valid: assert property (scaled_valid == $past(sum_valid))
        else $error("scaled_valid does not follow sum_valid");
    a_zero_in_zero: assert property (scaled_valid && $past(sum_sample) == 0 |-> scaled_sample == 0)
        else $error("zero sample gave nonzero output");
    a_neg_stays_neg: assert property (scaled_valid && $past(sum_sample[DW-1]) |-> scaled_sample[DW-1] || scaled_sample == 0)
        else $error("negative sample gave positive output");
    a_pos_stays_pos: assert property (scaled_valid && !$past(sum_sample[DW-1]) |-> !scaled_sample[DW-1])
        else $error("positive sample gave negative output");
    c_sample: cover property (sample_s);

    // ------------------------------------------------------------
    // Interrupt pin and channel enables
    // ------------------------------------------------------------
    // Event-to-pin latency is two samples; a depth of three is accepted as well
    sequence quiet_s;
        (irq_n && !any_ev && spi_cs_n)[*3];
    endsequence
    a_irq_fall_cause: assert property ($fell(irq_n) |-> $past(any_ev, 2) || $past(any_ev, 3))
        else $error("irq_n fell without an event");
    a_irq_quiet_high: assert property (quiet_s |=> irq_n)
        else $error("irq_n fell with no event and no host access");
    a_irq_rise_cause: assert property ($rose(irq_n) |-> !$past(spi_cs_n, 2) || !$past(handoff_aligned_event, 2))
        else $error("irq_n released without a clear or alignment drop");
    a_chan_host_only: assert property (!$stable(channel_on) |-> !$past(spi_cs_n))
        else $error("channel_on changed outside a serial frame");
endmodule

bind dac_event_status dac_event_status_sva #(.DW(DW), .CW(CW)) u_sva (
    .clk(clk),
    .arst_n(arst_n),
    .spi_cs_n(spi_cs_n),
    .sum_sample(sum_sample),
    .sum_valid(sum_valid),
    .scaled_sample(scaled_sample),
    .scaled_valid(scaled_valid),
    .parity_fault_event(parity_fault_event),
    .self_test_finished_event(self_test_finished_event),
    .param_update_set_event(param_update_set_event),
    .param_update_cleared_event(param_update_cleared_event),
    .handoff_aligned_event(handoff_aligned_event),
    .handoff_lost_event(handoff_lost_event),
    .overflow_event(overflow_event),
    .channel_on(channel_on),
    .irq_n(irq_n)
);

/* File: testbench/spi_host_model.sv */
// Purpose: Host controller on the serial configuration port.
// Assumes: Mode 0, MSB first, 16-bit instruction then one data byte.
// Notes:   sclk rests low between frames; sdi is inverted on release so stale data is not seen.
`timescale 1ns/1ps
module spi_host_model
    import dac_event_pkg::*;
(
    input wire logic clk,
    input wire logic sdo,
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // Low phase of four cycles leaves room for the fall detect and the sdo register
    task automatic shift(input logic b, output logic q);
        sdi = b;
        repeat (4) @(posedge clk);
        #1;
        q = sdo;
        sclk = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        sclk = 1'b0;
    endtask

    task automatic xfer(input logic rd, input reg_addr_t a, input reg_byte_t d, output reg_byte_t q);
        logic [15:0] ins;
        logic x;
        ins = {rd, 2'b00, a};
        repeat (2) @(posedge clk);
        #1;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) shift(ins[i], x);
        for (int i = 7; i >= 0; i--) shift(d[i], q[i]);
        repeat (4) @(posedge clk);
        #1;
        cs_n = 1'b1;
        sdi = ~sdi;
    endtask
endmodule

/* File: testbench/tb_dac_event_status.sv */
// Purpose: Self-checking bench for the event/status block.
// Assumes: ce high except in one freeze check; events driven as one-cycle pulses, alignment as a level.
// Notes:   Registers are reached only through the serial host model.
`timescale 1ns/1ps
`include "dac_event_defs.svh"
module tb_dac_event_status
    import dac_event_pkg::*;
;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] ev = 8'h00;
    logic [15:0] smp = 16'h0000;
    logic sv = 1'b0;
    logic ce = 1'b1;
    wire cs_n, sclk, sdi, sdo, sdo_oe, scv, irq_n;
    wire [15:0] scs;
    wire [3:0] chon;
    int err_count = 0;
    int total_checks = 0;
    reg_byte_t q;

    always #2.5 clk = ~clk;

    spi_host_model u_host (.clk(clk), .sdo(sdo), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));

    dac_event_status u_dut (
        .clk(clk), .arst_n(arst_n), .ce(ce),
        .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
        .sum_sample(smp), .sum_valid(sv), .scaled_sample(scs), .scaled_valid(scv),
        .parity_fault_event(ev[7]), .self_test_finished_event(ev[6]), .param_update_set_event(ev[5]),
        .param_update_cleared_event(ev[4]), .handoff_aligned_event(ev[3]), .handoff_lost_event(ev[2]),
        .overflow_event(ev[1]), .channel_on(chon), .irq_n(irq_n)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input reg_addr_t a, input reg_byte_t e);
        fork
            u_host.xfer(1'b1, a, 8'h00, q);
            begin
                repeat (120) @(posedge clk);
                #1;
                chk("spi_sdo_oe", 16'h0001, {15'h0000, sdo_oe});
            end
        join
        @(posedge clk);
        #1;
        chk("spi_sdo_oe", 16'h0000, {15'h0000, sdo_oe});
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
    endtask
    task automatic wr(input reg_addr_t a, input reg_byte_t d);
        u_host.xfer(1'b0, a, d, q);
    endtask
    task automatic pulse(input int b);
        @(posedge clk);
        #1;
        ev[b] = 1'b1;
        @(posedge clk);
        #1;
        ev[b] = 1'b0;
    endtask
    task automatic samp(input logic [15:0] s, input logic [15:0] e);
        @(posedge clk);
        #1;
        smp = s;
        sv = 1'b1;
        @(posedge clk);
        #1;
        sv = 1'b0;
        chk("scaled_valid", 16'h0001, {15'h0000, scv});
        chk("scaled_sample", e, scs);
    endtask
    task automatic wait_irq(input logic e);
        repeat (4) @(posedge clk);
        #1;
        chk("irq_n", {15'h0000, e}, {15'h0000, irq_n});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h00);
        rd(`OFS_PARITY_FAULT_COUNT, 8'h00);
        rd(`OFS_EVENT_ENABLE_MASK, 8'h00);
        rd(`OFS_EVENT_STATUS_CLEAR, 8'h00);
        rd(`OFS_CHANNEL_ON_MASK, 8'h00);
        rd(`OFS_SUMMING_GAIN, 8'h0D);
        rd(13'h0010, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_channels;
        reg_byte_t cv[4] = '{8'h01, 8'h0E, 8'hFF, 8'h00};
        foreach (cv[i]) begin
            wr(`OFS_CHANNEL_ON_MASK, cv[i]);
            rd(`OFS_CHANNEL_ON_MASK, cv[i] & 8'h0F);
            chk("channel_on", {12'h000, cv[i][3:0]}, {12'h000, chon});
        end
        $display("test channels done");
    endtask

    task automatic t_events;
        wr(`OFS_EVENT_ENABLE_MASK, 8'hFF);
        rd(`OFS_EVENT_ENABLE_MASK, 8'hFE);
        for (int b = 7; b >= 1; b--) begin
            if (b != 3) begin
                pulse(b);
                wait_irq(1'b0);
                rd(`OFS_EVENT_STATUS_CLEAR, 8'h01 << b);
                wr(`OFS_EVENT_STATUS_CLEAR, 8'h01 << b);
                rd(`OFS_EVENT_STATUS_CLEAR, 8'h00);
                wait_irq(1'b1);
            end
        end
        @(posedge clk);
        #1;
        ev[3] = 1'b1;
        wait_irq(1'b0);
        wr(`OFS_EVENT_STATUS_CLEAR, 8'h08);
        rd(`OFS_EVENT_STATUS_CLEAR, 8'h08);
        @(posedge clk);
        #1;
        ev[3] = 1'b0;
        wait_irq(1'b1);
        rd(`OFS_EVENT_STATUS_CLEAR, 8'h00);
        wr(`OFS_EVENT_ENABLE_MASK, 8'h00);
        pulse(2);
        wait_irq(1'b1);
        rd(`OFS_EVENT_STATUS_CLEAR, 8'h00);
        $display("test events done");
    endtask

    task automatic t_counters;
        wr(`OFS_EVENT_STATUS_CLEAR, 8'h80);
        rd(`OFS_PARITY_FAULT_COUNT, 8'h00);
        @(posedge clk);
        #1;
        ce = 1'b0;
        pulse(7);
        ce = 1'b1;
        rd(`OFS_PARITY_FAULT_COUNT, 8'h00);
        repeat (3) pulse(7);
        rd(`OFS_PARITY_FAULT_COUNT, 8'h03);
        repeat (260) pulse(7);
        rd(`OFS_PARITY_FAULT_COUNT, 8'hFF);
        samp(16'h7FFF, 16'h19FF);
        samp(16'hFFC0, 16'hFFF3);
        wr(`OFS_SUMMING_GAIN, 8'hFF);
        samp(16'h1000, 16'h3FC0);
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h00);
        samp(16'h7FFF, 16'h7FFF);
        samp(16'h8000, 16'h8000);
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h02);
        wr(`OFS_CLIP_SAMPLE_COUNT, 8'h55);
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h02);
        wr(`OFS_EVENT_STATUS_CLEAR, 8'h80);
        rd(`OFS_PARITY_FAULT_COUNT, 8'h00);
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h02);
        wr(`OFS_EVENT_STATUS_CLEAR, 8'h02);
        rd(`OFS_CLIP_SAMPLE_COUNT, 8'h00);
        $display("test counters done");
    endtask

    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clk);
        #1;
        arst_n = 1'b1;
        t_reset();
        t_channels();
        t_events();
        t_counters();
        close_out();
    end

    // Whole run needs roughly 9k cycles; allow a wide margin
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out();
    end
endmodule
